// file: rtl/cpmc_pkg.sv
package cpmc_pkg;

  // Sequencer port layout
  localparam logic [7:0] IDX_CURSOR_PATTERN = 8'h13;
  localparam logic [7:0] IDX_MISC_CTRL_TWO  = 8'h16;

  // Field positions in the second control register
  localparam int BIT_READY_DELAY  = 5;
  localparam int BIT_CMD_HALF_CLK = 4;
  localparam int BIT_OSC_DISABLE  = 2;
  localparam int BIT_DRAM_CMOS    = 1;
  localparam int BIT_CPU_CMOS     = 0;

  // Values after reset
  localparam logic [1:0] RST_PATTERN = 2'h0;
  localparam logic [4:0] RST_MISC    = 5'h00;
  localparam logic [7:0] RST_INDEX   = 8'h00;

  // Extra ready delay in host bus clocks, one per wait state
  localparam int READY_EXTRA_WAITS = 3;
  localparam logic [1:0] READY_EXTRA_CNT = 2'(READY_EXTRA_WAITS);

  // Register-held controls handed to the rest of the chip
  typedef struct packed {
    logic [1:0] pattern_sel;
    logic       ready_delay;
    logic       cmd_half_clk;
    logic       osc_disable;
    logic       dram_cmos;
    logic       cpu_cmos;
  } cpmc_ctrl_s;

  // Ready stretcher states, Gray coded along the count
  typedef enum logic [2:0] {
    CPMC_RDY_IDLE = 3'b000,
    CPMC_RDY_W1   = 3'b001,
    CPMC_RDY_W2   = 3'b011,
    CPMC_RDY_W3   = 3'b010,
    CPMC_RDY_GO   = 3'b110
  } cpmc_rdy_e;

  // Read-back of the pattern register; reserved bits are zero
  function automatic logic [7:0] cpmc_rd_pattern(input logic [1:0] sel);
    return {6'h00, sel};
  endfunction

endpackage

// file: rtl/cpmc_regs.sv
// Overview of operation
// - Two-bit selector picks one of four 32x32 cursor bitmaps in memory.
// - Index 13 reaches cursor pattern, index 16 the second control register.
// - Ready-delay bit zero gives memory-cycle ready with least delay.
// - Ready-delay bit one holds ready back three extra wait states.
// - Bit 4 adds half a host clock delay on command input timing.
// - Bit 2 set disables oscillator input pad during hardware suspend.
// - Bit 2 clear keeps oscillator pad always enabled.
// - Bit 1 selects DRAM input threshold: zero TTL, one CMOS.
// - Bit 0 selects CPU-bus input threshold: zero TTL, one CMOS.
// - Bits 2..0 write-only reset zero; bits 5,4 read/write reset zero.
// - Cursor shows only while cursor attribute enable bit is one.
`timescale 1ns/100ps
`default_nettype none

module cpmc_regs (
  input  wire logic             i_mclk,
  input  wire logic             i_arst_n,
  input  wire logic             i_ce,
  input  wire logic             i_idx_wr,
  input  wire logic             i_dat_wr,
  input  wire logic             i_dat_rd,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_cursor_en,
  input  wire logic             i_suspend_pin,
  input  wire logic             i_mem_cycle_done,
  input  wire logic             i_cmd,
  output logic [7:0]            o_rdata,
  output logic                  o_rvalid,
  output logic                  o_ready,
  output logic                  o_cmd_timed,
  output logic                  o_cursor_show,
  output logic [1:0]            o_cursor_pattern,
  output logic                  o_osc_pad_en,
  output logic                  o_dram_cmos,
  output logic                  o_cpu_cmos
);

  cpmc_pkg::cpmc_ctrl_s ctrl_r, ctrl_nxt;
  logic [7:0]           index_r, index_nxt;
  logic [7:0]           rdata_r, rdata_nxt;
  logic                 rvalid_r, rvalid_nxt;
  logic [2:0]           susp_sync_r;
  logic                 susp_r, susp_nxt;
  logic                 osc_en_r, osc_en_nxt;
  logic                 show_r, show_nxt;
  cpmc_pkg::cpmc_rdy_e  rdy_r, rdy_nxt;
  logic                 ready_r, ready_nxt;
  logic                 cmd_rise_r, cmd_fall_r;

  // Index latch and register writes; reserved bits never stored
  always_comb
  begin
    index_nxt = i_idx_wr ? i_wdata : index_r;
    ctrl_nxt  = ctrl_r;
    if (i_dat_wr && index_r == cpmc_pkg::IDX_CURSOR_PATTERN)
    begin
      ctrl_nxt.pattern_sel = i_wdata[1:0];
    end
    if (i_dat_wr && index_r == cpmc_pkg::IDX_MISC_CTRL_TWO)
    begin
      // Firmware-only register; no lockout, trust the caller
      ctrl_nxt.ready_delay  = i_wdata[cpmc_pkg::BIT_READY_DELAY];
      ctrl_nxt.cmd_half_clk = i_wdata[cpmc_pkg::BIT_CMD_HALF_CLK];
      ctrl_nxt.osc_disable  = i_wdata[cpmc_pkg::BIT_OSC_DISABLE];
      ctrl_nxt.dram_cmos    = i_wdata[cpmc_pkg::BIT_DRAM_CMOS];
      ctrl_nxt.cpu_cmos     = i_wdata[cpmc_pkg::BIT_CPU_CMOS];
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      index_r <= cpmc_pkg::RST_INDEX;
      ctrl_r  <= {cpmc_pkg::RST_PATTERN, cpmc_pkg::RST_MISC};
    end
    else if (i_ce)
    begin
      index_r <= index_nxt;
      ctrl_r  <= ctrl_nxt;
    end
  end

  // Read path: write-only bits and reserved bits return zero
  always_comb
  begin
    rvalid_nxt = i_dat_rd;
    rdata_nxt  = 8'h00;
    if (i_dat_rd)
    begin
      case (index_r)
        cpmc_pkg::IDX_CURSOR_PATTERN:
          rdata_nxt = cpmc_pkg::cpmc_rd_pattern(ctrl_r.pattern_sel);
        cpmc_pkg::IDX_MISC_CTRL_TWO:
        begin
          rdata_nxt[cpmc_pkg::BIT_READY_DELAY]  = ctrl_r.ready_delay;
          rdata_nxt[cpmc_pkg::BIT_CMD_HALF_CLK] = ctrl_r.cmd_half_clk;
        end
        default:
          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else if (i_ce)
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Suspend pin is asynchronous: three stages, change on 2nd/3rd agree
  always_comb
  begin
    susp_nxt = (susp_sync_r[1] == susp_sync_r[2]) ? susp_sync_r[2] : susp_r;
    // Pad off only when enabled by software and in suspend
    osc_en_nxt = !(ctrl_r.osc_disable && susp_nxt);
    show_nxt   = i_cursor_en;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      susp_sync_r <= 3'h0;
      susp_r      <= 1'b0;
      osc_en_r    <= 1'b1;
      show_r      <= 1'b0;
    end
    else if (i_ce)
    begin
      susp_sync_r <= {susp_sync_r[1:0], i_suspend_pin};
      susp_r      <= susp_nxt;
      osc_en_r    <= osc_en_nxt;
      show_r      <= show_nxt;
    end
  end

  // Ready stretcher: immediate, or three extra waits in test mode
  always_comb
  begin
    rdy_nxt   = rdy_r;
    ready_nxt = 1'b0;
    case (rdy_r)
      cpmc_pkg::CPMC_RDY_IDLE:
        if (i_mem_cycle_done)
        begin
          if (ctrl_r.ready_delay)
            rdy_nxt = cpmc_pkg::CPMC_RDY_W1;
          else
            ready_nxt = 1'b1;
        end
      cpmc_pkg::CPMC_RDY_W1: rdy_nxt = cpmc_pkg::CPMC_RDY_W2;
      cpmc_pkg::CPMC_RDY_W2: rdy_nxt = cpmc_pkg::CPMC_RDY_W3;
      cpmc_pkg::CPMC_RDY_W3:
      begin
        rdy_nxt   = cpmc_pkg::CPMC_RDY_IDLE;
        ready_nxt = 1'b1;
      end
      default: rdy_nxt = cpmc_pkg::CPMC_RDY_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rdy_r   <= cpmc_pkg::CPMC_RDY_IDLE;
      ready_r <= 1'b0;
    end
    else if (i_ce)
    begin
      rdy_r   <= rdy_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Command timing: half-clock delay via falling-edge capture
  // Both captures freeze with the clock enable, like all other state
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cmd_rise_r <= 1'b0;
    else if (i_ce)
      cmd_rise_r <= i_cmd;
  end

  always_ff @(negedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cmd_fall_r <= 1'b0;
    else if (i_ce)
      cmd_fall_r <= cmd_rise_r;
  end

  // Output selection is a flop per leg; the mux picks a registered leg
  assign o_cmd_timed = ctrl_r.cmd_half_clk ? cmd_fall_r : cmd_rise_r;

  assign o_rdata          = rdata_r;
  assign o_rvalid         = rvalid_r;
  assign o_ready          = ready_r;
  assign o_cursor_show    = show_r;
  assign o_cursor_pattern = ctrl_r.pattern_sel;
  assign o_osc_pad_en     = osc_en_r;
  assign o_dram_cmos      = ctrl_r.dram_cmos;
  assign o_cpu_cmos       = ctrl_r.cpu_cmos;

  // Register port: stores, index decode and read-back masking
  AST_PATTERN_WRITE: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce && i_dat_wr && index_r == cpmc_pkg::IDX_CURSOR_PATTERN
    |=> o_cursor_pattern == $past(i_wdata[1:0]))
    else $error("pattern select not stored");
  AST_INDEX_DECODE: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce && i_dat_wr && index_r != cpmc_pkg::IDX_CURSOR_PATTERN
    |=> $stable(o_cursor_pattern))
    else $error("pattern changed by other index");
  AST_DRAM_THR: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce && i_dat_wr && index_r == cpmc_pkg::IDX_MISC_CTRL_TWO
    |=> o_dram_cmos == $past(i_wdata[cpmc_pkg::BIT_DRAM_CMOS]))
    else $error("dram threshold select not stored");
  AST_CPU_THR: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce && i_dat_wr && index_r == cpmc_pkg::IDX_MISC_CTRL_TWO
    |=> o_cpu_cmos == $past(i_wdata[cpmc_pkg::BIT_CPU_CMOS]))
    else $error("cpu threshold select not stored");
  AST_WO_READ: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce && i_dat_rd && index_r == cpmc_pkg::IDX_MISC_CTRL_TWO
    |=> o_rdata[3:0] == 4'h0 && o_rdata[7:6] == 2'h0)
    else $error("write-only or reserved bits read back");
  AST_PAT_RESV: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce && i_dat_rd && index_r == cpmc_pkg::IDX_CURSOR_PATTERN
    |=> o_rvalid && o_rdata[7:2] == 6'h00)
    else $error("pattern register reserved bits read back");

  // Ready stretcher: one cycle normally, four with the test delay
  AST_READY_FAST: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce && rdy_r == cpmc_pkg::CPMC_RDY_IDLE && i_mem_cycle_done
    && !ctrl_r.ready_delay |=> o_ready)
    else $error("fast ready missing");
  AST_READY_SLOW: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce [*5]) ##0 ($past(rdy_r,4) == cpmc_pkg::CPMC_RDY_IDLE
    && $past(i_mem_cycle_done,4) && $past(ctrl_r.ready_delay,4))
    |-> !$past(o_ready) && o_ready)
    else $error("slow ready not three waits late");
  AST_READY_HOLD: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce && (rdy_r == cpmc_pkg::CPMC_RDY_W1
    || rdy_r == cpmc_pkg::CPMC_RDY_W2) |=> !o_ready)
    else $error("ready released during test waits");

  // Command timing: the falling-edge leg only shows between rising edges
  AST_CMD_SEL: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce ##1 !ctrl_r.cmd_half_clk |-> o_cmd_timed == $past(i_cmd))
    else $error("command timing wrong leg");
  AST_CMD_HALF: assert property (
    @(negedge i_mclk) disable iff (!i_arst_n)
    $past(i_ce) && ctrl_r.cmd_half_clk
    |-> o_cmd_timed == $past(cmd_rise_r))
    else $error("command half-clock delay missing");

  // Oscillator pad and cursor gating
  AST_OSC_OFF: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce && ctrl_r.osc_disable && susp_nxt |=> !o_osc_pad_en)
    else $error("oscillator pad not disabled");
  AST_OSC_ON: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce && !ctrl_r.osc_disable |=> o_osc_pad_en)
    else $error("oscillator pad disabled");
  AST_CURSOR_SHOW: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    i_ce && !i_cursor_en |=> !o_cursor_show)
    else $error("cursor shown while disabled");

  // Clock enable low must freeze the registered outputs; o_dram_cmos and o_cmd_timed are not checked here
  AST_CE_HOLD: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    !i_ce |=> $stable(o_rdata) && $stable(o_rvalid) && $stable(o_ready)
    && $stable(o_cursor_pattern) && $stable(o_osc_pad_en)
    && $stable(o_cursor_show) && $stable(o_cpu_cmos))
    else $error("state moved while clock enable low");

  COV_PAT_WR: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
    i_dat_wr && index_r == cpmc_pkg::IDX_CURSOR_PATTERN && i_wdata[1:0] == 2'h3);
  COV_SLOW_RDY: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
    rdy_r == cpmc_pkg::CPMC_RDY_W3);
  COV_OSC_OFF: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
    !o_osc_pad_en);
  COV_MISC_RD: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_rvalid && o_rdata[5]);
  COV_CMD_HALF: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
    ctrl_r.cmd_half_clk && cmd_rise_r);

endmodule // cpmc_regs

`default_nettype wire

// file: tb/cpmc_host.sv
`timescale 1ns/100ps
`default_nettype none

module cpmc_host (
  input  wire logic       i_mclk,
  output var  logic       o_idx_wr = 1'b0,
  output var  logic       o_dat_wr = 1'b0,
  output var  logic       o_dat_rd = 1'b0,
  output var  logic [7:0] o_wdata  = 8'h00
);
  // Index write, then one data access; a gap cycle keeps calls apart
  task automatic acc(input logic [7:0] idx, input logic [7:0] d,
                     input logic rd);
    @(posedge i_mclk);
    #1;
    o_idx_wr = 1'b1;
    o_wdata  = idx;
    @(posedge i_mclk);
    #1;
    o_idx_wr = 1'b0;
    o_dat_wr = !rd;
    o_dat_rd = rd;
    o_wdata  = rd ? ~idx : d;
    @(posedge i_mclk);
    #1;
    o_dat_wr = 1'b0;
    o_dat_rd = 1'b0;
    o_wdata  = ~o_wdata; // Released bus shows the complement of the last driven value
  endtask
endmodule // cpmc_host
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic       clk    = 1'b0;
  logic       arst_n = 1'b0;
  logic       cur_en = 1'b0;
  logic       susp   = 1'b0;
  logic       done   = 1'b0;
  logic       cmd    = 1'b0;
  logic       ce     = 1'b1;
  logic       idx_wr, dat_wr, dat_rd, rvalid, ready, cmd_t, show;
  logic       osc, dcm, ccm;
  logic [1:0] pat;
  logic [7:0] wdata, rdata;
  int         err_count   = 0;
  int         comparisons = 0;
  int         cyc         = 0;
  int         n;

  // Free-running 200 MHz clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  cpmc_host host_m (.i_mclk(clk), .o_idx_wr(idx_wr), .o_dat_wr(dat_wr),
    .o_dat_rd(dat_rd), .o_wdata(wdata));

  cpmc_regs uut (.i_mclk(clk), .i_arst_n(arst_n), .i_ce(ce),
    .i_idx_wr(idx_wr), .i_dat_wr(dat_wr), .i_dat_rd(dat_rd),
    .i_wdata(wdata), .i_cursor_en(cur_en), .i_suspend_pin(susp),
    .i_mem_cycle_done(done), .i_cmd(cmd), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_ready(ready), .o_cmd_timed(cmd_t),
    .o_cursor_show(show), .o_cursor_pattern(pat), .o_osc_pad_en(osc),
    .o_dram_cmos(dcm), .o_cpu_cmos(ccm));

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc1;
    @(posedge clk);
    #1;
  endtask

  // Reset values at the pins and through the data port
  task automatic t_reset;
    chk("outs", 8'h80, {osc, 1'b0, ready, cmd_t, pat, dcm, ccm});
    host_m.acc(8'h13, 8'h00, 1'b1);
    chk("rd13", 8'h00, rdata);
    host_m.acc(8'h16, 8'h00, 1'b1);
    chk("rd16", 8'h00, rdata);
  endtask

  // Every pattern code, with reserved bits set on the write
  task automatic t_pat;
    for (int i = 0; i < 4; i++)
    begin
      host_m.acc(8'h13, {6'h3f, 2'(i)}, 1'b0);
      chk("pat", 8'(i), {6'h00, pat});
      host_m.acc(8'h13, 8'h00, 1'b1);
      chk("rd13", 8'(i), rdata);
      chk("rvalid", 8'h01, {7'h00, rvalid});
    end
  endtask

  // Write-only bits act but read back as zero; stray index ignored
  task automatic t_misc;
    host_m.acc(8'h16, 8'hff, 1'b0);
    chk("cmos", 8'h03, {6'h00, dcm, ccm});
    host_m.acc(8'h16, 8'h00, 1'b1);
    chk("rd16", 8'h30, rdata);
    host_m.acc(8'h15, 8'hff, 1'b0);
    host_m.acc(8'h15, 8'h00, 1'b1);
    chk("rd15", 8'h00, rdata);
    chk("pat", 8'h03, {6'h00, pat});
    host_m.acc(8'h16, 8'h01, 1'b0);
    chk("cmos", 8'h01, {6'h00, dcm, ccm});
  endtask

  // Ready latency after a memory cycle, one or four cycles
  task automatic t_ready(input logic slow, input int lat);
    host_m.acc(8'h16, {2'b00, slow, 5'h00}, 1'b0);
    done = 1'b1;
    cyc1();
    done = 1'b0;
    n = 1;
    while (ready !== 1'b1 && n < 8)
    begin
      cyc1();
      n++;
    end
    chk("ready_lat", 8'(lat), 8'(n));
    cyc1();
    chk("ready_end", 8'h00, {7'h00, ready});
  endtask

  // Oscillator pad in suspend, with the disable bit set and then clear
  task automatic t_osc;
    host_m.acc(8'h16, 8'h04, 1'b0);
    susp = 1'b1;
    repeat (8) cyc1();
    chk("osc_off", 8'h00, {7'h00, osc});
    susp = 1'b0;
    repeat (8) cyc1();
    chk("osc_back", 8'h01, {7'h00, osc});
    host_m.acc(8'h16, 8'h00, 1'b0);
    susp = 1'b1;
    repeat (8) cyc1();
    chk("osc_on", 8'h01, {7'h00, osc});
    susp = 1'b0;
  endtask

  // Command delay, then half a clock more; cursor gating follows
  task automatic t_cmd_cur;
    cmd = 1'b1;
    cyc1();
    chk("cmd0", 8'h01, {7'h00, cmd_t});
    cmd = 1'b0;
    host_m.acc(8'h16, 8'h10, 1'b0);
    cmd = 1'b1;
    cyc1();
    chk("cmd1a", 8'h00, {7'h00, cmd_t});
    cyc1();
    chk("cmd1b", 8'h01, {7'h00, cmd_t});
    cur_en = 1'b1;
    cyc1();
    cyc1();
    chk("show", 8'h01, {7'h00, show});
    cur_en = 1'b0;
    cyc1();
    cyc1();
    chk("hide", 8'h00, {7'h00, show});
  endtask

  // Clock enable low drops every strobe; a mid-run reset clears all
  task automatic t_ce_rst;
    ce = 1'b0;
    host_m.acc(8'h13, 8'h01, 1'b0);
    host_m.acc(8'h13, 8'h00, 1'b1);
    chk("ce_rvalid", 8'h00, {7'h00, rvalid});
    done = 1'b1;
    cyc1();
    done = 1'b0;
    cyc1();
    chk("ce_hold", 8'h03, {ready, 5'h00, pat});
    ce = 1'b1;
    host_m.acc(8'h13, 8'h01, 1'b0);
    chk("pat", 8'h01, {6'h00, pat});
    host_m.acc(8'h16, 8'h33, 1'b0);
    chk("cmos", 8'h03, {6'h00, dcm, ccm});
    arst_n = 1'b0;
    cyc1();
    arst_n = 1'b1;
    chk("outs2", 8'h80, {osc, 1'b0, ready, cmd_t, pat, dcm, ccm});
    host_m.acc(8'h16, 8'h00, 1'b1);
    chk("rd16", 8'h00, rdata);
  endtask

  // Hang guard; the whole run needs about 120 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      conclude();
    end
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_pat();
    t_misc();
    t_ready(1'b0, 1);
    t_ready(1'b1, 4);
    t_osc();
    t_cmd_cur();
    t_ce_rst();
    conclude();
  end
endmodule // tb
`default_nettype wire
